// ==== dmw_ctrl_model.sv ====
// controller model driving the command pins of the mode word block
`timescale 1ns/1ps
module dmw_ctrl_model (
  input  wire logic   clk_in,
  output logic [3:0]  cmd_n_out,
  output logic [1:0]  bank_out,
  output logic [13:0] addr_out,
  output logic        idle_out
);
  // deselected, all banks precharged at start
  initial begin
    cmd_n_out = 4'hF;
    bank_out = 2'h3;
    addr_out = 14'h0;
    idle_out = 1'b1;
  end
  // one command held for a full cycle; no burst stop code is ever sent
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a, input logic i);
    @(negedge clk_in);
    cmd_n_out = c;
    bank_out = b;
    addr_out = a;
    idle_out = i;
    @(negedge clk_in);
    cmd_n_out = 4'hF;
    bank_out = ~b; // released lines lose their value
    addr_out = ~a;
    idle_out = 1'b1;
  endtask : cmd
endmodule : dmw_ctrl_model

// ==== dmw_defs.svh ====
// constants for the mode word and burst sequencing block
// How it works
// - mode load with both bank bits low, all banks idle, clock enable high latches address.
// - address bit 12 picks fast (0) or slow (1) power-down exit delay.
// - bits 11..9 give store recovery 2..6 cycles; 000, 110, 111 reserved.
// - recovery cycles plus precharge period give auto-precharge store delay.
// - bit 8 set to one requests a clock alignment loop reset.
// - bits 6..4 give CAS latency 3..6; other codes reserved.
// - address bit 13 exists only on the eight-bit organisation.
// - bit 3 picks sequential (0) or interleaved (1) burst order.
// - bits 2..0 give burst length, 010 four beats, 011 eight beats.
// - eight beats: full interleave, or sequential wrapping nibble then other nibble.
// - four beats: sequential start plus n mod 4, interleaved start xor n.
// - eight beats: interleave start xor n; sequential wraps low bits per nibble.
// - back-to-back bursts of one kind flow without gaps.
// - eight-beat read only cut by read, write only by write.
// - no early burst termination command exists.
`ifndef DMW_DEFS_SVH
`define DMW_DEFS_SVH
`define DMW_WORD_W        14
`define DMW_PD_BIT        12
`define DMW_WR_HI         11
`define DMW_WR_LO         9
`define DMW_DLL_BIT       8
`define DMW_TM_BIT        7
`define DMW_CL_HI         6
`define DMW_CL_LO         4
`define DMW_BT_BIT        3
`define DMW_BL_HI         2
`define DMW_BL_LO         0
`define DMW_BL4_CODE      3'h2
`define DMW_BL8_CODE      3'h3
`define DMW_PRECHARGE_NS  15
`define DMW_CLK_NS        20
`define DMW_PRECHARGE_CYC ((`DMW_PRECHARGE_NS + `DMW_CLK_NS - 1) / `DMW_CLK_NS)
`define DMW_FAST_EXIT_CYC 2
`define DMW_SLOW_EXIT_CYC 7
`endif

// ==== dmw_order.sv ====
// column order generator for one burst beat
`timescale 1ns/1ps
module dmw_order (
  dmw_seq_if.order seq
);
  wire [1:0] low_seq = 2'(seq.start[1:0] + seq.beat[1:0]); // wrap in nibble
  wire       hi_seq  = seq.start[2] ^ seq.beat[2];           // then other nibble
  wire [2:0] ilv     = seq.start ^ seq.beat;                 // xor order
  wire [2:0] seq8    = {hi_seq, low_seq};
  wire [2:0] seq4    = {seq.start[2], low_seq};
  wire [2:0] ilv4    = {seq.start[2], ilv[1:0]};
  // select by length and order
  assign seq.column = seq.eight ? (seq.interleave ? ilv : seq8)
                                : (seq.interleave ? ilv4 : seq4);
endmodule : dmw_order

// ==== dmw_pkg.sv ====
// types for the mode word and burst sequencing block
package dmw_pkg;
  typedef enum logic [1:0] {DMW_IDLE, DMW_READ, DMW_WRITE} dmw_burst_t;
endpackage : dmw_pkg

// ==== dmw_seq_if.sv ====
// carrier between burst engine and column order generator
`timescale 1ns/1ps
interface dmw_seq_if;
  logic [2:0] start;
  logic [2:0] beat;
  logic       interleave;
  logic       eight;
  logic [2:0] column;
  modport engine (output start, output beat, output interleave, output eight, input column);
  modport order  (input start, input beat, input interleave, input eight, output column);
endinterface : dmw_seq_if

// ==== dmw_top.sv ====
// mode word register and burst column sequencer
`timescale 1ns/1ps
`include "dmw_defs.svh"
module dmw_top #(
  parameter bit WIDE8 = 1'b1
) (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        cs_n_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic        cke_in,
  input  wire logic [1:0]  bank_in,
  input  wire logic [13:0] addr_in,
  input  wire logic        all_idle_in,
  output logic [13:0]      operating_mode_word_out,
  output logic             powerdown_exit_select_out,
  output logic [3:0]       exit_delay_cyc_out,
  output logic [2:0]       store_recovery_cyc_out,
  output logic [3:0]       autoprecharge_store_delay_out,
  output logic             dll_reset_out,
  output logic             test_mode_bit_out,
  output logic [2:0]       cas_latency_out,
  output logic             burst_order_select_out,
  output logic [3:0]       burst_beats_out,
  output logic             reserved_code_out,
  output logic             burst_active_out,
  output logic             burst_is_write_out,
  output logic [2:0]       column_out,
  output logic             illegal_interrupt_out
);
  // command decode
  wire cmd_sel   = ~cs_n_in;
  wire is_mode   = cmd_sel & ~ras_n_in & ~cas_n_in & ~we_n_in;
  wire mode_load = is_mode & (bank_in == 2'h0) & all_idle_in & cke_in;
  wire is_read   = cmd_sel & ras_n_in & ~cas_n_in & we_n_in;
  wire is_write  = cmd_sel & ras_n_in & ~cas_n_in & ~we_n_in;
  wire is_col    = is_read | is_write;

  // word held by the device
  logic [13:0] mode_word;
  logic        dll_pulse;
  wire  [13:0] load_mask = WIDE8 ? 14'h3FFF : 14'h1FFF;

  // mode word register, undefined value modelled as zero
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_word <= 14'h0000;
      dll_pulse <= 1'b0;
    end else begin
      dll_pulse <= mode_load & addr_in[`DMW_DLL_BIT];
      if (mode_load) begin
        mode_word <= addr_in & load_mask;
      end
    end
  end

  // field decode
  wire [2:0] wr_code = mode_word[`DMW_WR_HI:`DMW_WR_LO];
  wire [2:0] cl_code = mode_word[`DMW_CL_HI:`DMW_CL_LO];
  wire [2:0] bl_code = mode_word[`DMW_BL_HI:`DMW_BL_LO];
  wire       wr_ok   = (wr_code >= 3'h1) && (wr_code <= 3'h5);
  wire       cl_ok   = (cl_code >= 3'h3) && (cl_code <= 3'h6);
  wire       bl8     = (bl_code == `DMW_BL8_CODE);
  wire       bl_ok   = bl8 || (bl_code == `DMW_BL4_CODE);
  wire [2:0] wr_cyc  = wr_ok ? 3'(wr_code + 3'h1) : 3'h0;
  wire [2:0] cl_cyc  = cl_ok ? cl_code : 3'h0;
  wire [3:0] bl_beats = bl8 ? 4'h8 : 4'h4;
  wire       pd_slow = mode_word[`DMW_PD_BIT];
  wire [3:0] precharge_cyc = 4'(`DMW_PRECHARGE_CYC);

  // burst engine state
  dmw_pkg::dmw_burst_t kind;
  logic [2:0] start;
  logic [2:0] beat;
  logic       bad_cut;
  wire  [2:0] last_beat = 3'(bl_beats - 4'h1);
  wire        at_end    = (kind != dmw_pkg::DMW_IDLE) && (beat == last_beat);
  wire        same_kind = (is_read && kind == dmw_pkg::DMW_READ) || (is_write && kind == dmw_pkg::DMW_WRITE);
  wire        cut_ok    = bl8 && same_kind;
  wire        mid       = (kind != dmw_pkg::DMW_IDLE) && !at_end;
  wire        take      = is_col && (!mid || cut_ok);
  wire        refuse    = is_col && mid && !cut_ok;

  dmw_pkg::dmw_burst_t next_kind;
  logic [2:0] next_beat;
  // next burst state; no stop command is decoded
  always_comb begin
    next_kind = kind;
    next_beat = beat;
    if (take) begin
      next_kind = is_write ? dmw_pkg::DMW_WRITE : dmw_pkg::DMW_READ;
      next_beat = 3'h0;
    end else if (at_end) begin
      next_kind = dmw_pkg::DMW_IDLE;
      next_beat = 3'h0;
    end else if (kind != dmw_pkg::DMW_IDLE) begin
      next_beat = 3'(beat + 3'h1);
    end
  end

  // burst registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      kind    <= dmw_pkg::DMW_IDLE;
      beat    <= 3'h0;
      start   <= 3'h0;
      bad_cut <= 1'b0;
    end else begin
      kind    <= next_kind;
      beat    <= next_beat;
      bad_cut <= refuse;
      if (take) begin
        start <= addr_in[2:0];
      end
    end
  end

  dmw_seq_if seq ();
  assign seq.start      = start;
  assign seq.beat       = beat;
  assign seq.interleave = mode_word[`DMW_BT_BIT];
  assign seq.eight      = bl8;
  dmw_order u_order (
    .seq (seq)
  );

  // registered outputs
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      column_out <= 3'h0;
      exit_delay_cyc_out <= 4'h0;
      autoprecharge_store_delay_out <= 4'h0;
    end else begin
      column_out <= seq.column;
      exit_delay_cyc_out <= pd_slow ? 4'(`DMW_SLOW_EXIT_CYC) : 4'(`DMW_FAST_EXIT_CYC);
      autoprecharge_store_delay_out <= 4'({1'b0, wr_cyc} + precharge_cyc);
    end
  end

  assign operating_mode_word_out   = mode_word;
  assign powerdown_exit_select_out = pd_slow;
  assign store_recovery_cyc_out    = wr_cyc;
  assign dll_reset_out             = dll_pulse;
  assign test_mode_bit_out         = mode_word[`DMW_TM_BIT];
  assign cas_latency_out           = cl_cyc;
  assign burst_order_select_out    = mode_word[`DMW_BT_BIT];
  assign burst_beats_out           = bl_beats;
  assign reserved_code_out         = !wr_ok || !cl_ok || !bl_ok || mode_word[`DMW_TM_BIT];
  assign burst_active_out          = (kind != dmw_pkg::DMW_IDLE);
  assign burst_is_write_out        = (kind == dmw_pkg::DMW_WRITE);
  assign illegal_interrupt_out     = bad_cut;

  // checks
  property p_load;
    @(posedge clk_in) disable iff (!arst_n_in)
      mode_load |=> (operating_mode_word_out == ($past(addr_in) & load_mask));
  endproperty
  a_load: assert property (p_load) else $error("mode word not latched");
  property p_wr;
    @(posedge clk_in) disable iff (!arst_n_in)
      (wr_code == 3'h5) |-> (store_recovery_cyc_out == 3'h6);
  endproperty
  a_wr: assert property (p_wr) else $error("recovery decode wrong");
  property p_dll;
    @(posedge clk_in) disable iff (!arst_n_in)
      (mode_load && addr_in[`DMW_DLL_BIT]) |=> dll_reset_out
        ##1 (dll_reset_out == $past(mode_load && addr_in[`DMW_DLL_BIT]));
  endproperty
  a_dll: assert property (p_dll) else $error("loop reset pulse wrong");
  property p_cl;
    @(posedge clk_in) disable iff (!arst_n_in)
      (cl_code == 3'h4) |-> (cas_latency_out == 3'h4);
  endproperty
  a_cl: assert property (p_cl) else $error("latency decode wrong");
  property p_x16;
    @(posedge clk_in) disable iff (!arst_n_in)
      mode_load |=> operating_mode_word_out[13] == (WIDE8 && $past(addr_in[13]));
  endproperty
  a_x16: assert property (p_x16) else $error("bit 13 on narrow part");
  sequence s_start4;
    is_col && !mid && !bl8 && !mode_word[3] && addr_in[1:0] == 2'h1;
  endsequence
  property p_seq4;
    @(posedge clk_in) disable iff (!arst_n_in)
      s_start4 |-> ##2 column_out[1:0] == 2'h1 ##1 column_out[1:0] == 2'h2
        ##1 column_out[1:0] == 2'h3 ##1 column_out[1:0] == 2'h0;
  endproperty
  a_seq4: assert property (p_seq4) else $error("four beat order wrong");
  property p_ilv;
    @(posedge clk_in) disable iff (!arst_n_in)
      burst_active_out && mode_word[3] |=> column_out == ($past(start) ^ $past(beat));
  endproperty
  a_ilv: assert property (p_ilv) else $error("interleave order wrong");
  property p_len;
    @(posedge clk_in) disable iff (!arst_n_in)
      (is_col && !mid && !bl8 && $stable(mode_word)) ##1 !is_col [*4] |=> !burst_active_out;
  endproperty
  a_len: assert property (p_len) else $error("burst length wrong");
  property p_cut;
    @(posedge clk_in) disable iff (!arst_n_in)
      (is_col && mid && !bl8) |=> illegal_interrupt_out;
  endproperty
  a_cut: assert property (p_cut) else $error("short burst cut not flagged");
  property p_seam;
    @(posedge clk_in) disable iff (!arst_n_in)
      (is_col && at_end) |=> burst_active_out && beat == 3'h0 && (burst_is_write_out == $past(is_write));
  endproperty
  a_seam: assert property (p_seam) else $error("seamless burst gap");

  // exit delay and auto-precharge delay, one cycle behind the word
  property p_exit_slow;
    @(posedge clk_in) disable iff (!arst_n_in)
      powerdown_exit_select_out |=> exit_delay_cyc_out == 4'(`DMW_SLOW_EXIT_CYC);
  endproperty
  a_exit_slow: assert property (p_exit_slow) else $error("slow exit delay wrong");
  property p_exit_fast;
    @(posedge clk_in) disable iff (!arst_n_in)
      !powerdown_exit_select_out |=> exit_delay_cyc_out == 4'(`DMW_FAST_EXIT_CYC);
  endproperty
  a_exit_fast: assert property (p_exit_fast) else $error("fast exit delay wrong");
  property p_apd;
    @(posedge clk_in) disable iff (!arst_n_in)
      (wr_code == 3'h2) |=> autoprecharge_store_delay_out == 4'(3 + `DMW_PRECHARGE_CYC);
  endproperty
  a_apd: assert property (p_apd) else $error("auto-precharge delay wrong");
  property p_dll_quiet;
    @(posedge clk_in) disable iff (!arst_n_in)
      !(mode_load && addr_in[`DMW_DLL_BIT]) |=> !dll_reset_out;
  endproperty
  a_dll_quiet: assert property (p_dll_quiet) else $error("loop reset without request");

  // reserved recovery and latency codes decode to zero, a reserved length to four beats; all raise the flag
  property p_tm;
    @(posedge clk_in) disable iff (!arst_n_in)
      test_mode_bit_out |-> reserved_code_out;
  endproperty
  a_tm: assert property (p_tm) else $error("test bit not flagged");
  property p_wr_rsv;
    @(posedge clk_in) disable iff (!arst_n_in)
      (wr_code == 3'h0 || wr_code > 3'h5) |-> store_recovery_cyc_out == 3'h0 && reserved_code_out;
  endproperty
  a_wr_rsv: assert property (p_wr_rsv) else $error("reserved recovery code used");
  property p_cl_rsv;
    @(posedge clk_in) disable iff (!arst_n_in)
      (cl_code < 3'h3 || cl_code == 3'h7) |-> cas_latency_out == 3'h0 && reserved_code_out;
  endproperty
  a_cl_rsv: assert property (p_cl_rsv) else $error("reserved latency code used");
  property p_cl3;
    @(posedge clk_in) disable iff (!arst_n_in)
      (cl_code == 3'h3) |-> cas_latency_out == 3'h3;
  endproperty
  a_cl3: assert property (p_cl3) else $error("latency three decode wrong");
  property p_bl8;
    @(posedge clk_in) disable iff (!arst_n_in)
      (bl_code == `DMW_BL8_CODE) |-> burst_beats_out == 4'h8;
  endproperty
  a_bl8: assert property (p_bl8) else $error("eight beat decode wrong");
  property p_bl_rsv;
    @(posedge clk_in) disable iff (!arst_n_in)
      !bl_ok |-> reserved_code_out && burst_beats_out == 4'h4;
  endproperty
  a_bl_rsv: assert property (p_bl_rsv) else $error("reserved length not flagged");

  // eight beat sequential order, start five, no cut in between
  sequence s_start8;
    is_col && !mid && bl8 && !mode_word[`DMW_BT_BIT] && addr_in[2:0] == 3'h5;
  endsequence
  sequence s_tail8;
    column_out == 3'h3 ##1 column_out == 3'h0;
  endsequence
  property p_seq8;
    @(posedge clk_in) disable iff (!arst_n_in)
      s_start8 ##1 !is_col [*7] |-> (column_out == 3'h2 && $past(column_out) == 3'h1
        && $past(column_out, 2) == 3'h4 && $past(column_out, 3) == 3'h7
        && $past(column_out, 4) == 3'h6 && $past(column_out, 5) == 3'h5) ##1 s_tail8;
  endproperty
  a_seq8: assert property (p_seq8) else $error("eight beat nibble order wrong");

  // four beat interleaved order, start one
  sequence s_ilv1;
    is_col && !mid && !bl8 && mode_word[`DMW_BT_BIT] && addr_in[1:0] == 2'h1;
  endsequence
  property p_ilv4;
    @(posedge clk_in) disable iff (!arst_n_in)
      s_ilv1 |-> ##2 column_out[1:0] == 2'h1 ##1 column_out[1:0] == 2'h0
        ##1 column_out[1:0] == 2'h3 ##1 column_out[1:0] == 2'h2;
  endproperty
  a_ilv4: assert property (p_ilv4) else $error("four beat interleave wrong");

  // burst interruption and natural end
  property p_cut8_ok;
    @(posedge clk_in) disable iff (!arst_n_in)
      (is_col && mid && cut_ok) |=> !illegal_interrupt_out && burst_active_out && beat == 3'h0;
  endproperty
  a_cut8_ok: assert property (p_cut8_ok) else $error("same kind cut not taken");
  property p_cut8_bad;
    @(posedge clk_in) disable iff (!arst_n_in)
      (is_col && mid && bl8 && !same_kind) |=> illegal_interrupt_out
        && burst_is_write_out == $past(burst_is_write_out);
  endproperty
  a_cut8_bad: assert property (p_cut8_bad) else $error("other kind cut not refused");
  property p_quiet;
    @(posedge clk_in) disable iff (!arst_n_in)
      !(is_col && mid && !cut_ok) |=> !illegal_interrupt_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("spurious interrupt flag");
  property p_end;
    @(posedge clk_in) disable iff (!arst_n_in)
      (at_end && !is_col) |=> !burst_active_out;
  endproperty
  a_end: assert property (p_end) else $error("burst did not end");
endmodule : dmw_top

// ==== tb_top.sv ====
// self-checking bench for the mode word and burst sequencer
`timescale 1ns/1ps
`include "dmw_defs.svh"
module tb_top;
  localparam int STORE_NS = 45; // recovery time of an assumed speed grade
  localparam logic [2:0] WRC = 3'((STORE_NS + `DMW_CLK_NS - 1) / `DMW_CLK_NS - 1);
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [3:0]  cmd_n, ex, apd, beats;
  logic [1:0]  bank;
  logic [13:0] addr, word;
  logic        idle, pd, dll, tm, bt, rsv, act, wr, bad;
  logic        cke = 1'b1;
  logic [2:0]  wrc, cl, col;
  int          num_errors = 0;
  int          check_count = 0;
  always #10 clk_in = ~clk_in;
  dmw_ctrl_model ctrl_u (.clk_in(clk_in), .cmd_n_out(cmd_n), .bank_out(bank), .addr_out(addr), .idle_out(idle));
  dmw_top dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .cs_n_in(cmd_n[3]), .ras_n_in(cmd_n[2]),
    .cas_n_in(cmd_n[1]), .we_n_in(cmd_n[0]), .cke_in(cke), .bank_in(bank), .addr_in(addr),
    .all_idle_in(idle), .operating_mode_word_out(word), .powerdown_exit_select_out(pd),
    .exit_delay_cyc_out(ex), .store_recovery_cyc_out(wrc), .autoprecharge_store_delay_out(apd),
    .dll_reset_out(dll), .test_mode_bit_out(tm), .cas_latency_out(cl), .burst_order_select_out(bt),
    .burst_beats_out(beats), .reserved_code_out(rsv), .burst_active_out(act),
    .burst_is_write_out(wr), .column_out(col), .illegal_interrupt_out(bad));
  // compare and count
  task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  // load the word and let one cycle pass
  task automatic load(input logic [13:0] w);
    ctrl_u.cmd(4'h0, 2'h0, w, 1'b1);
    @(negedge clk_in);
  endtask : load
  // every field but the test bit decoded, both exit speeds
  task automatic t_fields;
    logic [13:0] w;
    w = {1'b1, 1'b1, WRC, 1'b1, 1'b0, 3'h5, 1'b1, `DMW_BL8_CODE};
    ctrl_u.cmd(4'h0, 2'h0, w, 1'b1);
    check("dll", 14'h1, 14'(dll));
    @(negedge clk_in);
    check("word", w, word);
    check("pd", 14'h1, 14'(pd));
    check("wr", 14'(WRC + 3'h1), 14'(wrc));
    check("cl", 14'h5, 14'(cl));
    check("bt", 14'h1, 14'(bt));
    check("beats", 14'h8, 14'(beats));
    check("rsv", 14'h0, 14'(rsv));
    @(negedge clk_in);
    check("dll", 14'h0, 14'(dll));
    check("exit", 14'(`DMW_SLOW_EXIT_CYC), 14'(ex));
    check("apd", 14'(WRC + 3'h1 + `DMW_PRECHARGE_CYC), 14'(apd));
    load(14'h0432);
    @(negedge clk_in);
    check("exit", 14'(`DMW_FAST_EXIT_CYC), 14'(ex));
    check("dll", 14'h0, 14'(dll));
    ctrl_u.cmd(4'h0, 2'h1, 14'h0433, 1'b1); // other bank selected
    ctrl_u.cmd(4'h0, 2'h0, 14'h0433, 1'b0); // banks not idle
    cke = 1'b0;
    ctrl_u.cmd(4'h0, 2'h0, 14'h0433, 1'b1); // clock enable low
    cke = 1'b1;
    @(negedge clk_in);
    check("word", 14'h0432, word);
  endtask : t_fields
  // reserved codes and the test bit are flagged; reserved recovery and latency codes decode to zero
  task automatic t_reserved;
    logic [13:0] w [6] = '{14'h0032, 14'h0C32, 14'h0422, 14'h0472, 14'h04B2, 14'h0431};
    logic [5:0]  e [6] = '{6'h03, 6'h03, 6'h18, 6'h18, 6'h1B, 6'h1B};
    for (int i = 0; i < 6; i++) begin
      load(w[i]);
      check("rsv", 14'h1, 14'(rsv));
      check("tm", 14'(w[i][7]), 14'(tm));
      check("wr_cl", 14'(e[i]), 14'({wrc, cl}));
    end
  endtask : t_reserved
  // column order for every length, type and start
  task automatic t_order;
    logic [2:0] e;
    for (int m = 0; m < 4; m++) begin
      load({5'h02, 5'h03, m[0], m[1] ? `DMW_BL8_CODE : `DMW_BL4_CODE});
      for (int s = 0; s < 8; s++) begin
        ctrl_u.cmd(4'h5, 2'h0, 14'(s), 1'b1);
        @(negedge clk_in);
        for (int n = 0; n < (m[1] ? 8 : 4); n++) begin
          e = m[0] ? 3'(s ^ n) : {s[2] ^ (n > 3), 2'(s + n)};
          check("column", 14'(e), 14'(col));
          @(negedge clk_in);
        end
      end
    end
  endtask : t_order
  // second column command two cycles into a burst
  task automatic t_cut(input logic [13:0] w, input logic [3:0] c1, input logic [3:0] c2, input logic eb);
    load(w);
    ctrl_u.cmd(c1, 2'h0, 14'h0, 1'b1);
    ctrl_u.cmd(c2, 2'h0, 14'h6, 1'b1);
    check("illegal", 14'(eb), 14'(bad));
    @(negedge clk_in);
    if (!eb) check("column", 14'h6, 14'(col));
    repeat (10) @(negedge clk_in);
  endtask : t_cut
  // write following a write on its last beat
  task automatic t_seamless;
    load(14'h0432);
    ctrl_u.cmd(4'h4, 2'h0, 14'h1, 1'b1);
    repeat (2) @(negedge clk_in);
    ctrl_u.cmd(4'h4, 2'h0, 14'h2, 1'b1);
    check("active", 14'h3, 14'({act, wr}));
    check("beat3", 14'h0, 14'({bad, col}));
    @(negedge clk_in);
    check("next", 14'h2, 14'(col));
  endtask : t_seamless
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    repeat (4) @(negedge clk_in);
    check("reset", 14'h0, word);
    check("rst_dec", 14'h24, 14'({beats, rsv, act, bad}));
    arst_n_in = 1'b1;
    t_fields();
    t_reserved();
    t_order();
    t_cut(14'h0432, 4'h5, 4'h5, 1'b1);
    t_cut(14'h0433, 4'h5, 4'h4, 1'b1);
    t_cut(14'h0433, 4'h4, 4'h5, 1'b1);
    t_cut(14'h0433, 4'h5, 4'h5, 1'b0);
    t_cut(14'h0433, 4'h4, 4'h4, 1'b0);
    t_seamless();
    complete_run();
  end
  // watchdog well beyond the expected run
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule : tb_top
